// [spb_bist.sv]
// PN self-test, test-mode decode and output control for one lane
// Notes on behaviour
// R1 - Transmitter holds a 23rd-order PN generator used as self-test stimulus.
// R2 - Receiver analyzer of same order syncs to PN stream, checks each character.
// R3 - Generator and analyzer both use polynomial 1 + x^5 + x^23.
// R4 - On entering self-test, send two 4/1 sync sequences, then PN continuously.
// R5 - Mismatch count clears on self-test entry and updates while mode stays.
// R6 - Count drives the eight receive data outputs, bit 7 down to bit 0.
// R7 - Count saturates at all ones, never wraps.
// R8 - Running and match: error, control and idle flags all low.
// R9 - Running and mismatch: error high, control and idle low.
// R10 - Synchronized but analyzer unlocked: error and idle high, control low.
// R11 - Searching byte alignment: error and control high, idle low.
// R12 - Byte aligned, searching word alignment: all three flags high.
// R13 - Self-test ignores ten-bit select and forces byte interface mode.
// R14 - Self-test ignores alignment selects, uses byte-aligned with realignment.
// R15 - Self-test blocks disparity word events and ignores the request input.
// R16 - Self-test follows half-speed, double-rate, word-sync, recovered-clock settings.
// R17 - System picks clock and speed before applying the self-test selects.
// R18 - After self-test, system must re-establish byte and word sync.
// R19 - Loopback self-test combines loopback and self-test, start-up done internally.
// R20 - Board test mode floats all parallel outputs, data, status, clock.
// R21 - Board test mode keeps serial transmit drivers running.
// R22 - Normal operation needs loopback output enable low, else outputs float.
// R23 - Test selects and loopback pins choose the mode; high select reserved.
// R24 - Loopback returns transmit data internally; link held static unless enabled.
// R25 - Analyzer loads 23 bits, locks after a matching run, then grades characters.
`timescale 1ns/100ps
`include "spb_defs.svh"
module spb_bist
  import spb_pkg::*;
(
  // Clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // Test mode pins
  input wire logic test_select_low_i,
  input wire logic test_select_high_i,
  input wire logic loopback_enable_i,
  input wire logic loopback_output_enable_i,
  // Static configuration pins
  input wire spb_pkg::spb_cfg_type cfg_i,
  // Normal transmit path from system logic
  input wire spb_pkg::spb_char_type tx_char_i,
  // Receive side from the decoder and aligner
  input wire spb_pkg::spb_char_type rx_char_i,
  input wire logic rx_char_valid_i,
  input wire logic rx_byte_sync_i,
  input wire logic rx_word_sync_i,
  input wire spb_pkg::spb_status_type rx_status_i,
  input wire logic rx_clk_level_i,
  // Effective configuration towards transceiver core
  output spb_pkg::spb_cfg_type cfg_eff_o,
  output logic loopback_path_o,
  output logic tx_link_hold_o,
  output logic tx_link_pos_o,
  output logic tx_link_neg_o,
  // Character towards encoder, with back-pressure
  output spb_pkg::spb_char_type enc_char_o,
  output logic enc_valid_o,
  input wire logic enc_ready_i,
  // Parallel receive outputs; oe low means driving
  output logic [7:0] rx_data_o,
  output spb_pkg::spb_status_type rx_status_o,
  output logic rx_clk_o,
  output logic rx_out_oe_n_o,
  output spb_pkg::spb_mode_type mode_o,
  output logic analyzer_lock_o
);
  // Pin synchronisers, two flops each
  logic [3:0] pin_s1_reg;
  logic [3:0] pin_s2_reg;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pin_s1_reg <= 4'h0;
      pin_s2_reg <= 4'h0;
    end else if (clk_en_i) begin
      pin_s1_reg <= {test_select_high_i, test_select_low_i, loopback_enable_i,
                     loopback_output_enable_i};
      pin_s2_reg <= pin_s1_reg;
    end
  end
  wire logic tsh = pin_s2_reg[3];
  wire logic tsl = pin_s2_reg[2];
  wire logic loopback_enable = pin_s2_reg[1];
  wire logic loopback_output_enable = pin_s2_reg[0];

  // Mode decode
  wire spb_mode_type mode_dec = tsh ? SPB_MODE_RSVD : // [R23]
                                (tsl && loopback_enable) ? SPB_MODE_LOOP_BIST :
                                tsl ? SPB_MODE_BIST :
                                loopback_enable ? SPB_MODE_LOOP :
                                loopback_output_enable ? SPB_MODE_BOARD : SPB_MODE_NORMAL;
  wire logic bist_on = (mode_dec == SPB_MODE_BIST) || (mode_dec == SPB_MODE_LOOP_BIST);
  wire logic loop_on = (mode_dec == SPB_MODE_LOOP) || (mode_dec == SPB_MODE_LOOP_BIST);
  // Board mode and a stray loopback output enable in normal mode both float outputs
  wire logic float_on = (mode_dec == SPB_MODE_BOARD); // [R20] [R22]

  // Configuration override
  spb_cfg_type cfg_eff;
  always_comb begin
    cfg_eff = cfg_i; // [R16]
    if (bist_on) begin
      cfg_eff.ten_bit_interface_select = 1'b0; // [R13]
      cfg_eff.word_event_method_select = 1'b0; // [R14]
      cfg_eff.alignment_mode_select = 1'b0; // [R14]
      cfg_eff.word_event_generate_request = 1'b0; // [R15]
    end
  end

  // Transmit sequencer: sync events, then PN forever
  typedef enum logic [1:0] {
    SPB_TX_IDLE = 2'b00,
    SPB_TX_SYNC = 2'b01,
    SPB_TX_PN = 2'b10
  } spb_tx_state_type;
  spb_tx_state_type tx_state_reg;
  spb_tx_state_type tx_state_next;
  logic [2:0] sync_cnt_reg;
  logic [1:0] evt_cnt_reg;
  logic bist_d_reg;
  wire logic bist_entry = bist_on && !bist_d_reg;

  wire logic [22:0] gen_state;
  wire logic [7:0] gen_byte;
  wire logic buf_ready;
  wire logic tx_push = (tx_state_reg != SPB_TX_IDLE) && buf_ready;
  wire logic gen_step = (tx_state_reg == SPB_TX_PN) && buf_ready;
  wire logic sync_last = (sync_cnt_reg == 3'(`SPB_SYNC_CHARS));
  wire logic evt_last = (evt_cnt_reg == 2'(`SPB_SYNC_EVENTS - 1));

  spb_pn_gen u_gen ( // [R1]
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .load_i(bist_entry),
    .seed_i(`SPB_PN_SEED),
    .step_i(gen_step),
    .state_o(gen_state),
    .byte_o(gen_byte)
  );

  // 4/1 event: four commas then one data character
  wire spb_char_type sync_char = sync_last ? spb_char_type'{data: `SPB_CHAR_DATA, ctrl: 1'b0}
                                           : spb_char_type'{data: `SPB_CHAR_K28_5, ctrl: 1'b1};
  wire spb_char_type bist_char = (tx_state_reg == SPB_TX_SYNC) ? sync_char
                                 : spb_char_type'{data: gen_byte, ctrl: 1'b0};

  always_comb begin
    tx_state_next = tx_state_reg;
    unique case (tx_state_reg)
      SPB_TX_IDLE: if (bist_entry) tx_state_next = SPB_TX_SYNC; // [R4] [R19]
      SPB_TX_SYNC: if (buf_ready && sync_last && evt_last) tx_state_next = SPB_TX_PN;
      SPB_TX_PN: tx_state_next = SPB_TX_PN;
    endcase
    if (!bist_on) tx_state_next = SPB_TX_IDLE;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      tx_state_reg <= SPB_TX_IDLE;
      sync_cnt_reg <= 3'h0;
      evt_cnt_reg <= 2'h0;
      bist_d_reg <= 1'b0;
    end else if (clk_en_i) begin
      tx_state_reg <= tx_state_next;
      bist_d_reg <= bist_on;
      if (tx_state_reg != SPB_TX_SYNC) begin
        sync_cnt_reg <= 3'h0;
        evt_cnt_reg <= 2'h0;
      end else if (buf_ready) begin
        sync_cnt_reg <= sync_last ? 3'h0 : sync_cnt_reg + 3'h1; // [R4]
        if (sync_last) evt_cnt_reg <= evt_cnt_reg + 2'h1;
      end
    end
  end

  // Encoder feed through the two-entry buffer, so a stall drops no self-test character
  spb_skid u_buf (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .in_i(bist_on ? bist_char : tx_char_i),
    .in_valid_i(bist_on ? tx_push : 1'b1),
    .in_ready_o(buf_ready),
    .out_o(enc_char_o),
    .out_valid_o(enc_valid_o),
    .out_ready_i(enc_ready_i)
  );

  // Analyzer: seed from 23 received bits, then run as a local generator
  logic [22:0] ana_reg;
  logic [4:0] fill_reg;
  logic [2:0] run_reg;
  logic locked_reg;
  logic [7:0] err_cnt_reg;
  logic mis_reg;

  function automatic logic [22:0] spb_ana_step8(input logic [22:0] s);
    logic [22:0] r;
    r = s;
    for (int i = 0; i < 8; i++) begin
      r = {r[21:0], r[`SPB_PN_ORDER-1] ^ r[`SPB_PN_TAP-1]};
    end
    return r;
  endfunction : spb_ana_step8

  wire logic in_sync = rx_byte_sync_i && rx_word_sync_i;
  wire logic [22:0] ana_pred = spb_ana_step8(ana_reg); // [R3]
  wire logic ch_ok = (rx_char_i.data == ana_pred[7:0]) && !rx_char_i.ctrl; // [R2]
  wire logic ana_take = bist_on && in_sync && rx_char_valid_i;
  wire logic filling = (fill_reg < 5'(`SPB_LOCK_BITS));
  wire logic [7:0] cnt_inc = (err_cnt_reg == `SPB_CNT_MAX) ? err_cnt_reg
                             : err_cnt_reg + 8'h01; // [R7]

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || (clk_en_i && (bist_entry || !in_sync))) begin
      ana_reg <= 23'h000000;
      fill_reg <= 5'h00;
      run_reg <= 3'h0;
      locked_reg <= 1'b0;
      mis_reg <= 1'b0;
    end else if (clk_en_i && ana_take) begin
      if (filling) begin
        ana_reg <= {ana_reg[14:0], rx_char_i.data}; // [R25]
        fill_reg <= (fill_reg > 5'(`SPB_LOCK_BITS - 8)) ? 5'(`SPB_LOCK_BITS)
                    : fill_reg + 5'h08;
      end else begin
        ana_reg <= ana_pred;
        mis_reg <= locked_reg && !ch_ok;
        if (!locked_reg) begin
          if (!ch_ok) begin
            fill_reg <= 5'h00; // [R25]
            run_reg <= 3'h0;
          end else if (run_reg == 3'(`SPB_LOCK_RUN - 1)) begin
            locked_reg <= 1'b1;
          end else begin
            run_reg <= run_reg + 3'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) err_cnt_reg <= `SPB_CNT_RST;
    else if (clk_en_i) begin
      if (bist_entry) err_cnt_reg <= `SPB_CNT_RST; // [R5]
      else if (ana_take && !filling && locked_reg && !ch_ok) err_cnt_reg <= cnt_inc; // [R5]
    end
  end

  // Status code
  spb_status_type bist_status;
  always_comb begin
    if (!rx_byte_sync_i) bist_status = '{1'b1, 1'b1, 1'b0}; // [R11]
    else if (!rx_word_sync_i) bist_status = '{1'b1, 1'b1, 1'b1}; // [R12]
    else if (!locked_reg) bist_status = '{1'b1, 1'b0, 1'b1}; // [R10]
    else if (mis_reg) bist_status = '{1'b1, 1'b0, 1'b0}; // [R9]
    else bist_status = '{1'b0, 1'b0, 1'b0}; // [R8]
  end

  // Registered outputs
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rx_data_o <= 8'h00;
      rx_status_o <= '0;
      rx_clk_o <= 1'b0;
      rx_out_oe_n_o <= 1'b0;
      cfg_eff_o <= '0;
      loopback_path_o <= 1'b0;
      tx_link_hold_o <= 1'b0;
      tx_link_pos_o <= 1'b1;
      tx_link_neg_o <= 1'b0;
      mode_o <= SPB_MODE_NORMAL;
      analyzer_lock_o <= 1'b0;
    end else if (clk_en_i) begin
      rx_data_o <= bist_on ? err_cnt_reg : rx_char_i.data; // [R6]
      rx_status_o <= bist_on ? bist_status : rx_status_i;
      rx_clk_o <= rx_clk_level_i && cfg_eff.recovered_clock_enable;
      rx_out_oe_n_o <= float_on; // [R20]
      cfg_eff_o <= cfg_eff;
      loopback_path_o <= loop_on; // [R24]
      // Board mode leaves the serial drivers alone
      tx_link_hold_o <= loop_on && !loopback_output_enable; // [R24] [R21]
      tx_link_pos_o <= 1'b1;
      tx_link_neg_o <= 1'b0;
      mode_o <= mode_dec;
      analyzer_lock_o <= locked_reg;
    end
  end

  a_cnt_saturate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R7]
    clk_en_i && !bist_entry && err_cnt_reg == `SPB_CNT_MAX |=> err_cnt_reg == `SPB_CNT_MAX)
    else $error("mismatch count wrapped");
  a_cnt_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R5]
    clk_en_i && bist_entry |=> err_cnt_reg == 8'h00)
    else $error("count not cleared on entry");
  a_cnt_step: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R5]
    clk_en_i && !bist_entry && err_cnt_reg != 8'hFF |=>
      (err_cnt_reg == $past(err_cnt_reg)) || (err_cnt_reg == $past(err_cnt_reg) + 8'h01))
    else $error("count moved by other than one");
  a_data_count: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R6]
    clk_en_i && bist_on |=> rx_data_o == $past(err_cnt_reg))
    else $error("data outputs not showing count");
  a_status_nobyte: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R11]
    clk_en_i && bist_on && !rx_byte_sync_i |=> rx_status_o == 3'b110)
    else $error("wrong code while byte search");
  a_status_noword: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R12]
    clk_en_i && bist_on && rx_byte_sync_i && !rx_word_sync_i |=> rx_status_o == 3'b111)
    else $error("wrong code while word search");
  a_status_unlock: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R10]
    clk_en_i && bist_on && in_sync && !locked_reg |=> rx_status_o == 3'b101)
    else $error("wrong code while unlocked");
  a_status_locked: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R8] [R9]
    clk_en_i && bist_on && in_sync && locked_reg |=> rx_status_o == {$past(mis_reg), 2'b00})
    else $error("wrong code while locked");
  a_cfg_override: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R13] [R14] [R15]
    clk_en_i && bist_on |=> !cfg_eff_o.ten_bit_interface_select &&
      !cfg_eff_o.alignment_mode_select && !cfg_eff_o.word_event_generate_request)
    else $error("self-test config not forced");
  a_board_float: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R20]
    clk_en_i && mode_dec == SPB_MODE_BOARD |=> rx_out_oe_n_o && !tx_link_hold_o)
    else $error("board mode outputs not floated");
  sequence s_sync_phase;
    tx_state_reg == SPB_TX_SYNC;
  endsequence
  a_entry_sync: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R4]
    clk_en_i && bist_entry |=> s_sync_phase)
    else $error("sync events not started on entry");
endmodule : spb_bist

// [spb_defs.svh]
// Constants for the PN self-test block
`ifndef SPB_DEFS_SVH
`define SPB_DEFS_SVH
`define SPB_PN_ORDER 23
`define SPB_PN_TAP 5
`define SPB_PN_SEED 23'h7FFFFF
`define SPB_CNT_MAX 8'hFF
`define SPB_CNT_RST 8'h00
`define SPB_SYNC_EVENTS 2
`define SPB_SYNC_CHARS 4
`define SPB_LOCK_BITS 23
`define SPB_LOCK_RUN 4
`define SPB_CHAR_K28_5 8'hBC
`define SPB_CHAR_DATA 8'h4A
`endif

// [spb_far_end.sv]
// Far-end model: encoder sink that loops accepted characters back to the receive side
`timescale 1ns/100ps
module spb_far_end
  import spb_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Controls from the bench
  input wire logic stall_i,
  input wire logic corrupt_req_i,
  input wire logic byte_sync_i,
  input wire logic word_sync_i,
  // Encoder stream
  input wire spb_pkg::spb_char_type enc_char_i,
  input wire logic enc_valid_i,
  output logic enc_ready_o,
  // Receive side towards the block
  output spb_pkg::spb_char_type rx_char_o,
  output logic rx_char_valid_o,
  output logic rx_byte_sync_o,
  output logic rx_word_sync_o,
  output spb_pkg::spb_status_type rx_status_o,
  output logic rx_clk_level_o
);
  logic corrupt_reg;
  logic take;
  assign enc_ready_o = !stall_i;
  assign take = enc_valid_i && enc_ready_o;
  assign rx_byte_sync_o = byte_sync_i;
  assign rx_word_sync_o = word_sync_i;
  assign rx_status_o = '0;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rx_char_o <= '0;
      rx_char_valid_o <= 1'b0;
      rx_clk_level_o <= 1'b0;
      corrupt_reg <= 1'b0;
    end else begin
      rx_char_valid_o <= take;
      if (take) begin
        rx_char_o <= {enc_char_i.data ^ {7'h00, corrupt_reg}, enc_char_i.ctrl};
        rx_clk_level_o <= !rx_clk_level_o;
      end else begin
        // A character outside its valid cycle must not look like a repeat
        rx_char_o <= ~rx_char_o;
      end
      corrupt_reg <= corrupt_req_i || (corrupt_reg && !take);
    end
  end
endmodule : spb_far_end

// [spb_pkg.sv]
// Types shared by the PN self-test block
package spb_pkg;
  typedef enum logic [2:0] {
    SPB_MODE_NORMAL = 3'b000,
    SPB_MODE_LOOP = 3'b001,
    SPB_MODE_BIST = 3'b010,
    SPB_MODE_LOOP_BIST = 3'b011,
    SPB_MODE_BOARD = 3'b100,
    SPB_MODE_RSVD = 3'b101
  } spb_mode_type;
  typedef struct packed {
    logic rx_error_flag;
    logic rx_control_char_flag;
    logic rx_idle_flag;
  } spb_status_type;
  typedef struct packed {
    logic [7:0] data;
    logic ctrl;
  } spb_char_type;
  typedef struct packed {
    logic ten_bit_interface_select;
    logic half_speed_select;
    logic double_rate_select;
    logic word_event_method_select;
    logic alignment_mode_select;
    logic word_sync_enable;
    logic word_event_generate_request;
    logic recovered_clock_enable;
  } spb_cfg_type;
endpackage : spb_pkg

// [spb_pn_gen.sv]
// 23rd-order PN generator, one byte per step
`timescale 1ns/100ps
`include "spb_defs.svh"
module spb_pn_gen
  import spb_pkg::*;
(
  // Clock and control
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic load_i,
  input wire logic [22:0] seed_i,
  input wire logic step_i,
  // Pattern
  output logic [22:0] state_o,
  output logic [7:0] byte_o
);
  // Eight serial shifts of x^23 + x^5 + 1, the new bit enters at the bottom
  function automatic logic [22:0] spb_pn_step8(input logic [22:0] s);
    logic [22:0] r;
    r = s;
    for (int i = 0; i < 8; i++) begin
      r = {r[21:0], r[`SPB_PN_ORDER-1] ^ r[`SPB_PN_TAP-1]};
    end
    return r;
  endfunction : spb_pn_step8

  logic [22:0] state_reg;
  wire logic [22:0] state_next = load_i ? seed_i : spb_pn_step8(state_reg);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) state_reg <= `SPB_PN_SEED;
    else if (clk_en_i && (load_i || step_i)) state_reg <= state_next; // [R3]
  end

  assign state_o = state_reg;
  assign byte_o = state_reg[7:0];
endmodule : spb_pn_gen

// [spb_skid.sv]
// Two-entry buffer with valid/ready on both sides
`timescale 1ns/100ps
module spb_skid
  import spb_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // Fill side
  input wire spb_pkg::spb_char_type in_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // Drain side
  output spb_pkg::spb_char_type out_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  spb_char_type mem_reg [2];
  logic [1:0] cnt_reg;
  logic rd_reg;
  logic wr_reg;
  wire logic push = in_valid_i && in_ready_o;
  wire logic pop = out_valid_o && out_ready_i;

  assign in_ready_o = (cnt_reg != 2'h2);
  assign out_valid_o = (cnt_reg != 2'h0);
  assign out_o = mem_reg[rd_reg];

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 2'h0;
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
    end else if (clk_en_i) begin
      if (push) begin
        mem_reg[wr_reg] <= in_i;
        wr_reg <= ~wr_reg;
      end
      if (pop) rd_reg <= ~rd_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : spb_skid

// [tb.sv]
// Self-checking bench for the PN self-test block
`timescale 1ns/100ps
`include "spb_defs.svh"
module tb;
  import spb_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic tst_lo = 1'b0, tst_hi = 1'b0, loopback_enable = 1'b0, loopback_output_enable = 1'b0;
  logic stall = 1'b0, stall_force = 1'b0, corrupt_req = 1'b0;
  logic byte_sync = 1'b0, word_sync = 1'b0, cap_on = 1'b0, saw_err = 1'b0;
  logic [15:0] lfsr = 16'h002D;
  spb_cfg_type cfg = '0;
  spb_char_type tx_char = '0;
  spb_char_type rx_char, enc_char;
  spb_char_type cap_q[$];
  spb_status_type rx_status_in, rx_status_o;
  spb_cfg_type cfg_eff_o;
  spb_mode_type mode_o;
  logic rx_valid, rx_bsync, rx_wsync, rx_clk_lvl, enc_valid, enc_ready;
  logic loopback_path_o, tx_link_hold_o, tx_link_pos_o, tx_link_neg_o;
  logic rx_clk_o, rx_out_oe_n_o, analyzer_lock_o;
  logic [7:0] rx_data_o;
  int fail_count = 0, total_checks = 0, cycles = 0, acc_count = 0;
  int idx, n, k;
  logic [22:0] pn;
  logic [11:0] tbl [7] = '{12'h000, 12'h213, 12'h312, 12'h420, 12'h633, 12'h144, 12'hB50};

  always #25 sys_clk_i = !sys_clk_i;

  spb_bist dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1),
    .test_select_low_i(tst_lo), .test_select_high_i(tst_hi), .loopback_enable_i(loopback_enable),
    .loopback_output_enable_i(loopback_output_enable), .cfg_i(cfg), .tx_char_i(tx_char), .rx_char_i(rx_char),
    .rx_char_valid_i(rx_valid), .rx_byte_sync_i(rx_bsync), .rx_word_sync_i(rx_wsync),
    .rx_status_i(rx_status_in), .rx_clk_level_i(rx_clk_lvl), .cfg_eff_o(cfg_eff_o),
    .loopback_path_o(loopback_path_o), .tx_link_hold_o(tx_link_hold_o),
    .tx_link_pos_o(tx_link_pos_o), .tx_link_neg_o(tx_link_neg_o), .enc_char_o(enc_char),
    .enc_valid_o(enc_valid), .enc_ready_i(enc_ready), .rx_data_o(rx_data_o),
    .rx_status_o(rx_status_o), .rx_clk_o(rx_clk_o), .rx_out_oe_n_o(rx_out_oe_n_o),
    .mode_o(mode_o), .analyzer_lock_o(analyzer_lock_o));

  spb_far_end far_end (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .stall_i(stall),
    .corrupt_req_i(corrupt_req), .byte_sync_i(byte_sync), .word_sync_i(word_sync),
    .enc_char_i(enc_char), .enc_valid_i(enc_valid), .enc_ready_o(enc_ready),
    .rx_char_o(rx_char), .rx_char_valid_o(rx_valid), .rx_byte_sync_o(rx_bsync),
    .rx_word_sync_o(rx_wsync), .rx_status_o(rx_status_in), .rx_clk_level_o(rx_clk_lvl));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  // Reference pattern: eight shifts per character, new bit enters at the bottom
  function automatic logic [22:0] pn_next(input logic [22:0] s);
    for (int b = 0; b < 8; b++) s = {s[21:0], s[22] ^ s[4]};
    return s;
  endfunction : pn_next

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  // Mode pins move only after clock and configuration are settled
  task automatic set_pins(input logic [3:0] p);
    @(negedge sys_clk_i);
    {tst_hi, tst_lo, loopback_enable, loopback_output_enable} = p;
    repeat (6) @(negedge sys_clk_i);
  endtask : set_pins

  task automatic wait_lock();
    int w;
    w = 0;
    while (analyzer_lock_o !== 1'b1 && w < 2000) begin
      @(negedge sys_clk_i);
      w++;
    end
    check("analyzer_lock", 32'(analyzer_lock_o), 32'h1);
  endtask : wait_lock

  // Random back-pressure and normal traffic, both changed off the sampling edge
  always @(negedge sys_clk_i) begin
    lfsr <= lfsr_next(lfsr);
    stall <= stall_force | (lfsr[0] & lfsr[3]);
    tx_char <= {lfsr[15:8], 1'b0};
  end

  always @(posedge sys_clk_i) begin
    cycles++;
    if (enc_valid === 1'b1 && enc_ready === 1'b1) begin
      acc_count++;
      if (cap_on) cap_q.push_back(enc_char);
    end
    if (rx_status_o === 3'b100) saw_err = 1'b1;
    if (cycles == 30000) begin
      fail_count++;
      finish_test();
    end
  end

  initial begin
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    check("reset_mode", 32'(mode_o), 32'(SPB_MODE_NORMAL));
    check("reset_link_pos", 32'(tx_link_pos_o), 32'h1);
    cfg = lfsr[7:0];
    byte_sync = 1'b1;
    word_sync = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    check("cfg_normal", 32'(cfg_eff_o), 32'(cfg));
    check("rx_clk_gate", 32'(rx_clk_o & !cfg.recovered_clock_enable), 32'h0);
    for (int i = 0; i < 7; i++) begin
      set_pins(tbl[i][11:8]);
      check("mode", 32'(mode_o), 32'(tbl[i][6:4]));
      check("out_float", 32'(rx_out_oe_n_o), 32'(tbl[i][2]));
      if (i < 6) begin
        check("loop_path", 32'(loopback_path_o), 32'(tbl[i][1]));
        check("link_hold", 32'(tx_link_hold_o), 32'(tbl[i][0]));
      end
      if (tbl[i][0]) check("link_lvl", 32'({tx_link_pos_o, tx_link_neg_o}), 32'h2);
    end
    set_pins(4'h0);
    cap_q.delete();
    cap_on = 1'b1;
    set_pins(4'h4);
    check("cfg_bist", 32'(cfg_eff_o), 32'(cfg & 8'h65));
    wait_lock();
    repeat (10) @(negedge sys_clk_i);
    check("status_match", 32'(rx_status_o), 32'h0);
    check("count_clear", 32'(rx_data_o), 32'h0);
    idx = 0;
    while (idx < cap_q.size() && cap_q[idx].ctrl === 1'b0) idx++;
    // Sync events plus forty pattern characters must be captured before grading
    k = 0;
    while (cap_q.size() < idx + 50 && k < 500) begin
      @(negedge sys_clk_i);
      k++;
    end
    for (int e = 0; e < 10; e++) begin
      check("sync_char", 32'(cap_q[idx + e]),
        (e % 5 == 4) ? 32'({`SPB_CHAR_DATA, 1'b0}) : 32'({`SPB_CHAR_K28_5, 1'b1}));
    end
    pn = `SPB_PN_SEED;
    // The generator sends the low byte of its state, then advances eight shifts
    for (int e = 0; e < 40; e++) begin
      check("pn_char", 32'(cap_q[idx + 10 + e]), 32'({pn[7:0], 1'b0}));
      pn = pn_next(pn);
    end
    cap_on = 1'b0;
    saw_err = 1'b0;
    corrupt_req = 1'b1;
    @(negedge sys_clk_i);
    corrupt_req = 1'b0;
    repeat (30) @(negedge sys_clk_i);
    check("status_mismatch", 32'(saw_err), 32'h1);
    check("count_moved", 32'(rx_data_o != 8'h00), 32'h1);
    corrupt_req = 1'b1;
    n = acc_count + 300;
    k = 0;
    while (acc_count < n && k < 3000) begin
      @(negedge sys_clk_i);
      k++;
    end
    repeat (10) @(negedge sys_clk_i);
    check("count_saturate", 32'(rx_data_o), 32'hFF);
    corrupt_req = 1'b0;
    byte_sync = 1'b0;
    repeat (6) @(negedge sys_clk_i);
    check("status_no_byte", 32'(rx_status_o), 32'h6);
    check("lock_lost", 32'(analyzer_lock_o), 32'h0);
    byte_sync = 1'b1;
    word_sync = 1'b0;
    repeat (6) @(negedge sys_clk_i);
    check("status_no_word", 32'(rx_status_o), 32'h7);
    stall_force = 1'b1;
    word_sync = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    stall_force = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    stall_force = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    check("status_unlocked", 32'(rx_status_o), 32'h5);
    stall_force = 1'b0;
    set_pins(4'h0);
    // Leaving self-test: links are re-synchronized before further use
    byte_sync = 1'b0;
    word_sync = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    byte_sync = 1'b1;
    word_sync = 1'b1;
    set_pins(4'h4);
    check("count_reentry", 32'(rx_data_o), 32'h0);
    set_pins(4'h6);
    wait_lock();
    repeat (10) @(negedge sys_clk_i);
    check("loop_bist_match", 32'(rx_status_o), 32'h0);
    finish_test();
  end
endmodule : tb
